// ===== hw/cpu_timing_pkg.sv
// shared types and constants for the operand and timing decoder
`default_nettype none
package cpu_timing_pkg;
	localparam int          ADDR_W        = 24;           // full code address width
	localparam int          LEN_W         = 3;            // instruction length field
	localparam int          ST_W          = 6;            // state count field
	localparam int          WAIT_W        = 2;            // wait-state count width
	localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;        // first bit-addressable ram byte
	localparam logic [23:0] EXT_BIT_LO    = 24'h000020;   // extended bit area start
	localparam logic [23:0] EXT_BIT_HI    = 24'h00007f;   // extended bit area end
	localparam int          BLOCK_BITS    = 11;           // block target width
	localparam int          REGION_BITS   = 16;           // region target width
	localparam logic [2:0]  BR_TAKEN_ADD  = 3'h3;         // taken minus not-taken states
	localparam logic [2:0]  CARRY_BR_LEN  = 3'h2;         // carry branch length, both modes
	localparam logic [5:0]  PORT_ADD      = 6'h01;        // port access penalty
	localparam logic [5:0]  PERIPH_ADD    = 6'h02;        // peripheral register penalty
	localparam logic [5:0]  ODD_DEST_ADD  = 6'h01;        // odd internal destination penalty
	localparam logic [5:0]  EXT_N1        = 6'h01;        // constant in 2(n+1)
	localparam logic [5:0]  EXT_N2        = 6'h02;        // constant in n+2 forms

	// decoded instruction forms
	typedef enum logic [5:0] {
		cmp_rr_b, cmp_rr_w, cmp_rr_d, cmp_ri_b, cmp_ri_w, cmp_zx_d, cmp_ox_d,
		cmp_short_b, cmp_short_w, cmp_long_b, cmp_long_w, cmp_ind64_b, cmp_ind16m_b,
		mov_w_from_dis16m, mov_b_to_dis64, mov_w_to_dis64, mov_b_to_dis16m,
		mov_w_to_dis16m, mov_long_ext,
		br_carry, br_no_carry, br_equal, br_unequal, br_greater, br_less_equal,
		br_signed_less, br_signed_less_equal, br_signed_greater, br_signed_greater_equal,
		jmp_block, jmp_region, jmp_full
	} instr_form_t;

	// where the memory operand lands
	typedef enum logic [1:0] {
		space_internal, space_port, space_periph, space_external
	} target_space_t;

	// penalty class of a form
	typedef enum logic [2:0] {
		pen_none, pen_short, pen_n2, pen_2n2, pen_2n1, pen_4n2
	} penalty_t;

	// status flags used by the branch conditions
	typedef struct packed {
		logic carry;
		logic zero;
		logic neg;
		logic ovf;
	} flags_t;

	// one decode request
	typedef struct packed {
		logic                valid;
		instr_form_t         form;
		target_space_t       space;
		logic [WAIT_W-1:0]   wait_n;
		logic [ADDR_W-1:0]   pc;
		logic [7:0]          rel;
		logic [ADDR_W-1:0]   target;
		flags_t              flags;
		logic                internal_exec;
		logic                dest_internal;
		logic                bit_legacy;
		logic [7:0]          bit_num;
		logic [ADDR_W-1:0]   bit_addr;
		logic                bit_sfr_defined;
	} decode_req_t;

	// one decode answer
	typedef struct packed {
		logic                valid;
		logic [LEN_W-1:0]    length;
		logic [ST_W-1:0]     states;
		logic                taken;
		logic [ADDR_W-1:0]   next_pc;
		logic                bit_ok;
		logic                bit_is_sfr;
		logic [7:0]          bit_byte;
		logic [2:0]          bit_index;
	} decode_rsp_t;
endpackage : cpu_timing_pkg
`default_nettype wire

// ===== hw/cpu_operand_timing_decode.sv
// operand notation, branch target and state count decoder for the core
`default_nettype none
// Function
// - legacy low bits map to ram 20h-2Fh
// - legacy high bits map to x0h/x8h registers
// - extended bits valid 0020h-007Fh or defined register
// - relative offset signed 8-bit from next instruction
// - block target stays in same 2K block
// - region target stays in same 64K region
// - full target anywhere in 16M space
// - register compares 3/2 bytes, states per width
// - immediate compare state counts per width
// - short direct compare bytes and states
// - port adds one, peripheral register adds two
// - byte long or indirect external adds N+2
// - word long direct external adds 2(N+2)
// - word displacement transfer timing, external 2(N+1)
// - byte displacement store timing, external N+2
// - long transfer external adds 4(N+2)
// - advance pc, add offset only when taken
// - branch lengths and not-taken/taken states per mode
// - branch pairs read not-taken then taken
// - internal odd destination of a taken conditional branch adds one state
module cpu_operand_timing_decode #(
	parameter int WAIT_BITS = cpu_timing_pkg::WAIT_W   // width of the wait-state count
) (
	input  wire logic                         ref_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         source_mode_cfg,
	input  wire cpu_timing_pkg::decode_req_t  req,
	output var  cpu_timing_pkg::decode_rsp_t  rsp,
	output logic                              mode_is_source
);
	import cpu_timing_pkg::*;

	// the penalty arithmetic is sized for the package wait field;
	// refuse any other width while the design is being built
	if (WAIT_BITS != WAIT_W)
	begin : g_wait_width_check
		$error("wait count width must match the package field");
	end

	logic        mode_reg;          // latched encoding mode
	logic        mode_next;
	logic        mode_taken_reg;    // set once the mode has been caught
	decode_rsp_t rsp_reg;           // registered answer
	decode_rsp_t rsp_next;

	// binary-mode base length of a form
	// source mode takes one byte off, carry branches excepted
	function automatic logic [LEN_W-1:0] bin_len(input instr_form_t f);
		case (f)
			cmp_rr_b, cmp_rr_w, cmp_rr_d:                  bin_len = 3'h3;
			cmp_ri_b, cmp_short_b, cmp_short_w:            bin_len = 3'h4;
			cmp_ind64_b, cmp_ind16m_b:                     bin_len = 3'h4;
			br_carry, br_no_carry:                         bin_len = CARRY_BR_LEN;
			jmp_block:                                     bin_len = 3'h2;
			jmp_region:                                    bin_len = 3'h3;
			jmp_full:                                      bin_len = 3'h4;
			br_equal, br_unequal, br_greater, br_less_equal,
			br_signed_less, br_signed_less_equal,
			br_signed_greater, br_signed_greater_equal:    bin_len = 3'h3;
			default:                                       bin_len = 3'h5;
		endcase
	endfunction : bin_len

	// binary-mode base (not-taken) states of a form
	// conditional branches give their not-taken count here
	function automatic logic [ST_W-1:0] bin_states(input instr_form_t f);
		case (f)
			cmp_rr_b:                                      bin_states = 6'h02;
			cmp_rr_w:                                      bin_states = 6'h03;
			cmp_rr_d:                                      bin_states = 6'h05;
			cmp_ri_b:                                      bin_states = 6'h03;
			cmp_ri_w:                                      bin_states = 6'h04;
			cmp_zx_d, cmp_ox_d:                            bin_states = 6'h06;
			cmp_short_b:                                   bin_states = 6'h03;
			cmp_short_w:                                   bin_states = 6'h04;
			cmp_long_b, cmp_ind64_b:                       bin_states = 6'h03;
			cmp_long_w, cmp_ind16m_b:                      bin_states = 6'h04;
			mov_w_from_dis16m, mov_w_to_dis16m:            bin_states = 6'h08;
			mov_w_to_dis64:                                bin_states = 6'h07;
			mov_b_to_dis64:                                bin_states = 6'h06;
			mov_b_to_dis16m:                               bin_states = 6'h07;
			mov_long_ext:                                  bin_states = 6'h05;
			br_carry, br_no_carry:                         bin_states = 6'h01;
			jmp_block, jmp_region, jmp_full:               bin_states = 6'h03;
			default:                                       bin_states = 6'h02;
		endcase
	endfunction : bin_states

	// penalty class of a form
	// the space of each request decides whether the class costs anything
	function automatic penalty_t pen_class(input instr_form_t f);
		case (f)
			cmp_short_b, cmp_short_w:                      pen_class = pen_short;
			cmp_long_b, cmp_ind64_b, cmp_ind16m_b:         pen_class = pen_n2;
			mov_b_to_dis64, mov_b_to_dis16m:               pen_class = pen_n2;
			cmp_long_w:                                    pen_class = pen_2n2;
			mov_w_from_dis16m, mov_w_to_dis64,
			mov_w_to_dis16m:                               pen_class = pen_2n1;
			mov_long_ext:                                  pen_class = pen_4n2;
			default:                                       pen_class = pen_none;
		endcase
	endfunction : pen_class

	// true for the conditional relative branches
	// the absolute jumps are always taken and stay out of this set
	function automatic logic is_cond_branch(input instr_form_t f);
		case (f)
			br_carry, br_no_carry, br_equal, br_unequal, br_greater, br_less_equal,
			br_signed_less, br_signed_less_equal, br_signed_greater,
			br_signed_greater_equal:                       is_cond_branch = 1'b1;
			default:                                       is_cond_branch = 1'b0;
		endcase
	endfunction : is_cond_branch

	// branch condition from the status flags
	// unsigned ordering reads carry as borrow, signed ordering neg xor ovf
	function automatic logic cond_holds(input instr_form_t f, input flags_t fl);
		logic lt;
		lt = fl.neg ^ fl.ovf;
		case (f)
			br_carry:                cond_holds = fl.carry;
			br_no_carry:             cond_holds = ~fl.carry;
			br_equal:                cond_holds = fl.zero;
			br_unequal:              cond_holds = ~fl.zero;
			br_greater:              cond_holds = ~fl.carry & ~fl.zero;
			br_less_equal:           cond_holds = fl.carry | fl.zero;
			br_signed_less:          cond_holds = lt;
			br_signed_less_equal:    cond_holds = lt | fl.zero;
			br_signed_greater:       cond_holds = ~lt & ~fl.zero;
			br_signed_greater_equal: cond_holds = ~lt;
			default:                 cond_holds = 1'b0;
		endcase
	endfunction : cond_holds

	// extra states for the memory operand
	// the wait count is two bits, so the worst case, 4(n+2) at n of 3, is 20,
	// and no base count plus penalty can leave the six-bit state field
	// a class that meets the wrong space adds nothing
	function automatic logic [ST_W-1:0] penalty(input penalty_t p, input target_space_t s,
		input logic [WAIT_W-1:0] n);
		logic [ST_W-1:0] nw;
		nw = {{(ST_W-WAIT_W){1'b0}}, n};
		penalty = '0;
		case (p)
			pen_short:
			begin
				if (s == space_port)
					penalty = PORT_ADD;
				else if (s == space_periph)
					penalty = PERIPH_ADD;
			end
			pen_n2:
				if (s == space_external)
					penalty = nw + EXT_N2;
			pen_2n2:
				if (s == space_external)
					penalty = ST_W'((nw + EXT_N2) << 1);
			pen_2n1:
				if (s == space_external)
					penalty = ST_W'((nw + EXT_N1) << 1);
			pen_4n2:
				if (s == space_external)
					penalty = ST_W'((nw + EXT_N2) << 2);
			default:
				penalty = '0;
		endcase
	endfunction : penalty

	// encoding mode: caught once on the first clock after reset release
	// holding it keeps a strap that moves in mid-run from mixing the two
	// encodings inside one program
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mode_reg       <= 1'b0;
			mode_taken_reg <= 1'b0;
		end
		else
		begin
			mode_reg       <= mode_next;
			mode_taken_reg <= 1'b1;
		end
	end

	// hold the mode once caught, otherwise sample the setting
	// the first clock out of reset passes the strap straight through
	always_comb
	begin
		mode_next = mode_taken_reg ? mode_reg : source_mode_cfg;
	end

	// decode one request into length, states, target and bit map
	// every field is worked out each cycle whether or not valid is set;
	// the sequencer only uses the answer when the echoed valid is high
	always_comb
	begin
		logic [LEN_W-1:0]  len;
		logic [ST_W-1:0]   st;
		logic [ADDR_W-1:0] seq_pc;
		logic [ADDR_W-1:0] dest;
		logic              tk;
		logic              src;
		len    = '0;
		st     = '0;
		seq_pc = '0;
		dest   = '0;
		tk     = 1'b0;
		src    = mode_next;
		rsp_next = '0;
		rsp_next.valid = req.valid;
		// source mode drops the escape byte and one state, carry branches excepted
		len = bin_len(req.form);
		st  = bin_states(req.form);
		if (src && req.form != br_carry && req.form != br_no_carry)
		begin
			len = len - 3'h1;
			st  = st - 6'h01;
		end
		st = st + penalty(pen_class(req.form), req.space, req.wait_n);
		// sequential address first, then the branch target
		// the offset counts from the byte after the whole instruction
		seq_pc = req.pc + {{(ADDR_W-LEN_W){1'b0}}, len};
		dest   = seq_pc;
		if (is_cond_branch(req.form))
		begin
			tk = cond_holds(req.form, req.flags);
			if (tk)
			begin
				dest = seq_pc + {{(ADDR_W-8){req.rel[7]}}, req.rel};
				st   = st + {{(ST_W-3){1'b0}}, BR_TAKEN_ADD};
			end
		end
		else if (req.form == jmp_block)
		begin
			tk   = 1'b1;
			dest = {seq_pc[ADDR_W-1:BLOCK_BITS], req.target[BLOCK_BITS-1:0]};
		end
		else if (req.form == jmp_region)
		begin
			tk   = 1'b1;
			dest = {seq_pc[ADDR_W-1:REGION_BITS], req.target[REGION_BITS-1:0]};
		end
		else if (req.form == jmp_full)
		begin
			tk   = 1'b1;
			dest = req.target;
		end
		// odd internal destination costs one more when a conditional branch is taken
		if (tk && is_cond_branch(req.form) && req.internal_exec && req.dest_internal && dest[0])
			st = st + ODD_DEST_ADD;
		rsp_next.length  = len;
		rsp_next.states  = st;
		rsp_next.taken   = tk;
		rsp_next.next_pc = dest;
		// bit operand mapping
		// legacy numbers split at 80h: ram bits below, register bits above
		// extended addresses are range checked, registers by the defined flag
		if (req.bit_legacy)
		begin
			rsp_next.bit_ok    = 1'b1;
			rsp_next.bit_index = req.bit_num[2:0];
			if (!req.bit_num[7])
			begin
				rsp_next.bit_is_sfr = 1'b0;
				rsp_next.bit_byte   = BIT_RAM_BASE + {4'h0, req.bit_num[6:3]};
			end
			else
			begin
				rsp_next.bit_is_sfr = 1'b1;
				rsp_next.bit_byte   = {req.bit_num[7:3], 3'h0};
			end
		end
		else
		begin
			rsp_next.bit_index = req.bit_num[2:0];
			if (req.bit_addr >= EXT_BIT_LO && req.bit_addr <= EXT_BIT_HI)
			begin
				rsp_next.bit_ok   = 1'b1;
				rsp_next.bit_byte = req.bit_addr[7:0];
			end
			else if (req.bit_sfr_defined)
			begin
				rsp_next.bit_ok     = 1'b1;
				rsp_next.bit_is_sfr = 1'b1;
				rsp_next.bit_byte   = req.bit_addr[7:0];
			end
		end
	end

	// answer register
	// one-stage pipeline: each answer stands for exactly one clock
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			rsp_reg <= '0;
		else
			rsp_reg <= rsp_next;
	end

	assign rsp            = rsp_reg;
	assign mode_is_source = mode_reg;
endmodule : cpu_operand_timing_decode
`default_nettype wire

// ===== verification/cpu_operand_timing_decode_checker.sv
// concurrent checks on the decoder ports
`default_nettype none
module cpu_operand_timing_decode_checker #(
	parameter int WAIT_BITS = 2 // width of the wait-state count
) (
	input wire logic                        ref_clk,
	input wire logic                        sys_rst,
	input wire logic                        source_mode_cfg,
	input wire cpu_timing_pkg::decode_req_t req,
	input wire cpu_timing_pkg::decode_rsp_t rsp,
	input wire logic                        mode_is_source
);
	import cpu_timing_pkg::*;
	logic [1:0] up_reg; // edges since reset, saturating; skips the capture edge

	// count edges out of reset
	always_ff @(posedge ref_clk)
		if (sys_rst)
			up_reg <= 2'h0;
		else if (up_reg != 2'h2)
			up_reg <= up_reg + 2'h1;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// carry branch whose condition holds, and one whose does not
	sequence s_carry_go; up_reg != 2'h0 && req.form == br_carry && req.flags.carry; endsequence
	sequence s_carry_stay; up_reg != 2'h0 && req.form == br_carry && !req.flags.carry; endsequence

	property p_rel;
		s_carry_go |=> rsp.taken &&
			rsp.next_pc == $past(req.pc) + 24'h2 + 24'($signed($past(req.rel)));
	endproperty
	property p_stay;
		s_carry_stay |=> !rsp.taken && rsp.states == 6'h01 && rsp.next_pc == $past(req.pc) + 24'h2;
	endproperty
	property p_low;
		up_reg != 2'h0 && req.bit_legacy && !req.bit_num[7] |=> !rsp.bit_is_sfr &&
			rsp.bit_byte == BIT_RAM_BASE + ($past(req.bit_num) >> 3);
	endproperty
	property p_high;
		up_reg != 2'h0 && req.bit_legacy && req.bit_num[7] |=> rsp.bit_is_sfr &&
			rsp.bit_byte == ($past(req.bit_num) & 8'hf8);
	endproperty
	property p_block;
		up_reg != 2'h0 && req.form == jmp_block |=>
			(rsp.next_pc & 24'h7ff) == ($past(req.target) & 24'h7ff)
			&& (rsp.next_pc >> 11) == (($past(req.pc) + 24'(rsp.length)) >> 11);
	endproperty
	property p_full;
		up_reg != 2'h0 && req.form == jmp_full |=> rsp.next_pc == $past(req.target);
	endproperty
	property p_rr;
		up_reg != 2'h0 && req.form == cmp_rr_b |=> rsp.length == (mode_is_source ? 3'h2 : 3'h3)
			&& rsp.states == (mode_is_source ? 6'h01 : 6'h02);
	endproperty
	property p_port;
		up_reg != 2'h0 && req.form == cmp_short_b && req.space == space_port |=>
			rsp.states == (mode_is_source ? 6'h03 : 6'h04);
	endproperty
	property p_echo;
		up_reg != 2'h0 |=> rsp.valid == $past(req.valid);
	endproperty
	property p_mode;
		up_reg == 2'h2 |-> $stable(mode_is_source);
	endproperty

	a_rel: assert property (p_rel) else $error("taken branch target wrong");
	a_stay: assert property (p_stay) else $error("untaken branch wrong");
	a_low: assert property (p_low) else $error("low bit mapping wrong");
	a_high: assert property (p_high) else $error("high bit mapping wrong");
	a_block: assert property (p_block) else $error("block target wrong");
	a_full: assert property (p_full) else $error("full target wrong");
	a_rr: assert property (p_rr) else $error("register compare timing wrong");
	a_port: assert property (p_port) else $error("port penalty wrong");
	a_echo: assert property (p_echo) else $error("valid not echoed");
	a_mode: assert property (p_mode) else $error("mode changed");
endmodule : cpu_operand_timing_decode_checker

bind cpu_operand_timing_decode cpu_operand_timing_decode_checker #(.WAIT_BITS(WAIT_BITS)) chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .source_mode_cfg(source_mode_cfg),
	.req(req), .rsp(rsp), .mode_is_source(mode_is_source));
`default_nettype wire

// ===== verification/cpu_operand_timing_decode_test.sv
// self-checking bench for the decoder
`default_nettype none
module cpu_operand_timing_decode_test;
	timeunit 1ns;
	timeprecision 1ps;
	import cpu_timing_pkg::*;
	logic        ref_clk;         // core clock
	logic        sys_rst;         // synchronous reset
	logic        source_mode_cfg; // encoding mode strap
	decode_req_t req;             // request
	decode_rsp_t rsp;             // answer
	logic        mode_is_source;  // latched mode
	logic        src;             // mode under test
	int          errors;          // mismatches
	int          samples_checked; // comparisons
	int          cycles = 0;      // hang guard

	cpu_operand_timing_decode #(.WAIT_BITS(2)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.source_mode_cfg(source_mode_cfg), .req(req), .rsp(rsp), .mode_is_source(mode_is_source));

	// 200 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// cut a hang short
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic check_num(input logic [23:0] got, input logic [23:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask : check_num

	task automatic check_bit(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %0t %s got %b want %b", $time, what, got, exp);
		end
	endtask : check_bit

	// plain valid request of one form
	function automatic decode_req_t base(input instr_form_t f, input target_space_t s,
		input logic [1:0] n);
		decode_req_t r;
		r = '0;
		r.valid = 1'b1;
		r.form = f;
		r.space = s;
		r.wait_n = n;
		return r;
	endfunction : base

	// drive at a falling edge, answer is settled one falling edge later
	task automatic send(input decode_req_t r);
		req = r;
		@(negedge ref_clk);
	endtask : send

	// reset for 6 cycles, then flip the strap to show the mode holds
	task automatic do_reset(input logic m);
		sys_rst = 1'b1;
		source_mode_cfg = m;
		src = m;
		repeat (6) @(negedge ref_clk);
		sys_rst = 1'b0;
		@(negedge ref_clk);
		source_mode_cfg = ~m;
		@(negedge ref_clk);
		check_bit(mode_is_source, m, "mode");
	endtask : do_reset

	// binary figures given; source form is one byte and one state less
	task automatic t_time(input instr_form_t f, input target_space_t s, input logic [1:0] n,
		input int bl, input int bs, input int add);
		send(base(f, s, n));
		check_bit(rsp.valid, 1'b1, "valid");
		check_num(24'(rsp.length), 24'(bl - src), "length");
		check_num(24'(rsp.states), 24'(bs - src + add), "states");
	endtask : t_time

	task automatic t_compare();
		t_time(cmp_rr_b, space_internal, 2'h0, 3, 2, 0);
		t_time(cmp_rr_w, space_internal, 2'h0, 3, 3, 0);
		t_time(cmp_rr_d, space_internal, 2'h0, 3, 5, 0);
		t_time(cmp_ri_b, space_internal, 2'h0, 4, 3, 0);
		t_time(cmp_ri_w, space_internal, 2'h0, 5, 4, 0);
		t_time(cmp_zx_d, space_internal, 2'h0, 5, 6, 0);
		t_time(cmp_ox_d, space_internal, 2'h0, 5, 6, 0);
		t_time(cmp_short_b, space_internal, 2'h0, 4, 3, 0);
		t_time(cmp_short_b, space_port, 2'h0, 4, 3, 1);
		t_time(cmp_short_w, space_periph, 2'h0, 4, 4, 2);
		t_time(cmp_long_b, space_external, 2'h3, 5, 3, 5);
		t_time(cmp_ind64_b, space_external, 2'h0, 4, 3, 2);
		t_time(cmp_ind16m_b, space_external, 2'h1, 4, 4, 3);
		t_time(cmp_long_w, space_external, 2'h3, 5, 4, 10);
	endtask : t_compare

	task automatic t_transfer();
		t_time(mov_w_from_dis16m, space_internal, 2'h0, 5, 8, 0);
		t_time(mov_w_from_dis16m, space_external, 2'h2, 5, 8, 6);
		t_time(mov_w_to_dis64, space_external, 2'h3, 5, 7, 8);
		t_time(mov_w_to_dis16m, space_external, 2'h1, 5, 8, 4);
		t_time(mov_b_to_dis64, space_external, 2'h1, 5, 6, 3);
		t_time(mov_b_to_dis16m, space_internal, 2'h0, 5, 7, 0);
		t_time(mov_long_ext, space_external, 2'h2, 5, 5, 16);
	endtask : t_transfer

	// every condition against every flag pattern, both offset extremes
	task automatic t_branch();
		decode_req_t r;
		logic        z;
		logic        c;
		logic        lt;
		logic        ok;
		logic [9:0]  conds;
		logic [23:0] exp;
		int          ln;
		int          st;
		for (int i = 0; i < 10; i++)
			for (int f = 0; f < 16; f++)
			begin
				r = base(instr_form_t'(6'(br_carry) + 6'(i)), space_internal, 2'h0);
				r.flags = flags_t'(f[3:0]);
				r.pc = 24'h001000;
				r.rel = f[0] ? 8'h80 : 8'h7f;
				r.internal_exec = 1'b1;
				r.dest_internal = f[1];
				c = f[3];
				z = f[2];
				lt = f[1] ^ f[0];
				conds = {!lt, !(lt || z), lt || z, lt, c || z, !c && !z, !z, z, !c, c};
				ok = conds[i];
				ln = (i < 2) ? 2 : 3 - src;
				exp = r.pc + 24'(ln) + (ok ? 24'($signed(r.rel)) : 24'h0);
				st = ((i < 2) ? 1 : 2 - src) + (ok ? 3 : 0) + ((ok && f[1] && exp[0]) ? 1 : 0);
				send(r);
				check_bit(rsp.taken, ok, "taken");
				check_num(rsp.next_pc, exp, "next pc");
				check_num(24'(rsp.length), 24'(ln), "length");
				check_num(24'(rsp.states), 24'(st), "states");
			end
	endtask : t_branch

	// absolute targets that start next to a block or region boundary
	task automatic t_jump();
		decode_req_t r;
		logic [23:0] seq;
		r = base(jmp_block, space_internal, 2'h0);
		r.pc = 24'h0007fe;
		r.target = 24'h123456;
		seq = r.pc + 24'(2 - src);
		send(r);
		check_num(rsp.next_pc, {seq[23:11], r.target[10:0]}, "block");
		check_bit(rsp.taken, 1'b1, "jump taken");
		r.form = jmp_region;
		r.pc = 24'h00fffe;
		seq = r.pc + 24'(3 - src);
		send(r);
		check_num(rsp.next_pc, {seq[23:16], r.target[15:0]}, "region");
		r.form = jmp_full;
		send(r);
		check_num(rsp.next_pc, r.target, "full");
	endtask : t_jump

	// bit operands at the edges of each area
	task automatic t_bits();
		decode_req_t r;
		logic [7:0]  nums [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
		logic [23:0] adrs [5] = '{24'h000020, 24'h00007f, 24'h00001f, 24'h000080, 24'h000080};
		r = base(cmp_rr_b, space_internal, 2'h0);
		r.bit_legacy = 1'b1;
		foreach (nums[k])
		begin
			r.bit_num = nums[k];
			send(r);
			check_num(24'(rsp.bit_byte), nums[k][7] ? 24'(nums[k] & 8'hf8)
				: 24'h20 + 24'(nums[k][6:3]), "bit byte");
			check_bit(rsp.bit_is_sfr, nums[k][7], "bit area");
			check_num(24'(rsp.bit_index), 24'(nums[k][2:0]), "bit index");
			check_bit(rsp.bit_ok, 1'b1, "legacy bit ok");
		end
		r.bit_legacy = 1'b0;
		foreach (adrs[k])
		begin
			r.bit_addr = adrs[k];
			r.bit_sfr_defined = (k == 4);
			send(r);
			check_bit(rsp.bit_ok, k < 2 || k == 4, "bit ok");
			check_bit(rsp.bit_is_sfr, k == 4, "ext bit area");
			if (k < 2 || k == 4)
				check_num(24'(rsp.bit_byte), 24'(adrs[k][7:0]), "ext bit byte");
		end
		r.valid = 1'b0;
		send(r);
		check_bit(rsp.valid, 1'b0, "valid");
	endtask : t_bits

	// binary mode pass, then source mode pass
	initial
	begin
		errors = 0;
		samples_checked = 0;
		req = '0;
		sys_rst = 1'b1;
		source_mode_cfg = 1'b0;
		src = 1'b0;
		@(negedge ref_clk);
		for (int m = 0; m < 2; m++)
		begin
			do_reset(m[0]);
			t_compare();
			t_transfer();
			t_branch();
			t_jump();
			t_bits();
		end
		complete_run();
	end
endmodule : cpu_operand_timing_decode_test
`default_nettype wire
